// ===== common/drc_pkg.sv
// Package for the dynamic RAM access controller: timing, widths, carriers
`default_nettype none
package drc_pkg;
    localparam int unsigned CLK_PERIOD_NS = 10;    // 100 MHz system clock
    localparam int unsigned ADDR_W        = 12;    // 4096 words
    localparam int unsigned ROW_W         = 6;     // 64 rows
    localparam int unsigned ROW_COUNT     = 64;
    // Printed times in their own units
    localparam int unsigned REFRESH_LIMIT_MS = 2;
    localparam int unsigned CYCLE_PERIOD_NS  = 400;
    localparam int unsigned RMW_PERIOD_NS    = 520;
    localparam int unsigned ACCESS_LATENCY_NS = 200;
    localparam int unsigned STROBE_ON_NS     = 230;  // strobe high time
    localparam int unsigned RMW_ON_NS        = 350;  // strobe high in RMW
    localparam int unsigned ADDR_SETUP_NS    = 10;   // one cycle of setup
    localparam int unsigned WE_LEAD_NS       = 150;  // write low before fall
    localparam int unsigned DUTY_PCT         = 60;
    // Cycle counts; least times round up, the access bound rounds down
    localparam int unsigned CYCLE_CLKS  =
        (CYCLE_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned RMW_CLKS    =
        (RMW_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned ON_CLKS     =
        (STROBE_ON_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned RMW_ON_CLKS =
        (RMW_ON_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned SETUP_CLKS  =
        (ADDR_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned WE_CLKS     =
        (WE_LEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned ACC_CLKS    = ACCESS_LATENCY_NS / CLK_PERIOD_NS;
    // Refresh spacing: whole window split over rows, with margin of one row
    localparam int unsigned REFRESH_WINDOW_CLKS =
        REFRESH_LIMIT_MS * 1000000 / CLK_PERIOD_NS;
    localparam int unsigned REFRESH_GAP_CLKS =
        REFRESH_WINDOW_CLKS / (ROW_COUNT + 1);
    localparam int unsigned CNT_W = 16;
    localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_ONE  = 16'h0001;
    localparam logic [ROW_W-1:0] ROW_ZERO = 6'h00;
    localparam logic [ROW_W-1:0] ROW_ONE  = 6'h01;
    localparam logic [ADDR_W-1:0] ADDR_ZERO = 12'h000;

    // User request carrier
    typedef enum logic [1:0] {
        DRC_OP_READ,
        DRC_OP_WRITE,
        DRC_OP_RMW
    } drc_op_t;

    typedef struct packed {
        drc_op_t             op;
        logic [ADDR_W-1:0]   addr;
        logic                wdata;
    } drc_req_t;

    // Pins toward the memory
    typedef struct packed {
        logic                strobe;    // cycle strobe, high active
        logic                sel_n;     // select, low active
        logic                wr_n;      // write strobe, low active
        logic [ADDR_W-1:0]   addr;
        logic                din;
    } drc_pins_t;
endpackage
`default_nettype wire

// ===== hdl/drc_refresh_timer.sv
// Refresh pacing timer and row counter for the dynamic RAM controller
`default_nettype none
module drc_refresh_timer
    import drc_pkg::*;
#(
    parameter int unsigned GAP_CLKS = REFRESH_GAP_CLKS
) (
    input  wire logic               mclk_i,
    input  wire logic               rstn_i,
    input  wire logic               ce_i,
    input  wire logic               done_i,    // refresh cycle issued
    output logic                    due_o,     // refresh pending
    output logic [ROW_W-1:0]        row_o      // next row to refresh
);
    logic [31:0]      cnt_r;                    // Gap counter
    logic [31:0]      cnt_nxt;
    logic             due_r;                    // Sticky request
    logic             due_nxt;
    logic [ROW_W-1:0] row_r;                    // Row walker
    logic [ROW_W-1:0] row_nxt;

    // Next state: tick every gap, walk rows in turn
    always_comb begin
        cnt_nxt = cnt_r + 32'h0000_0001;
        due_nxt = due_r;
        row_nxt = row_r;
        if (done_i) begin
            due_nxt = 1'b0;
            row_nxt = row_r + ROW_ONE;
        end
        // Tick wins over a clear in the same cycle
        if (cnt_r >= GAP_CLKS - 1) begin
            cnt_nxt = 32'h0000_0000;
            due_nxt = 1'b1;
        end
    end

    // Register stage
    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            cnt_r <= 32'h0000_0000;
            due_r <= 1'b0;
            row_r <= ROW_ZERO;
        end else if (ce_i) begin
            cnt_r <= cnt_nxt;
            due_r <= due_nxt;
            row_r <= row_nxt;
        end
    end

    assign due_o = due_r;
    assign row_o = row_r;
endmodule
`default_nettype wire

// ===== hdl/drc_ctrl.sv
// Host-side controller that runs read, write, RMW and refresh cycles
`default_nettype none
module drc_ctrl #(
    parameter int unsigned REFRESH_GAP = drc_pkg::REFRESH_GAP_CLKS
) (
    input  wire logic                 mclk_i,
    input  wire logic                 rstn_i,
    input  wire logic                 ce_i,        // Clock enable
    // User side
    input  wire logic                 req_valid_i,
    input  wire drc_pkg::drc_req_t    req_i,
    output logic                      req_ready_o,
    input  wire logic                 rmw_wdata_i,  // Data for RMW write
    output logic                      rd_valid_o,   // One-cycle pulse
    output logic                      rd_data_o,
    output logic                      busy_o,
    // Memory pins
    output drc_pkg::drc_pins_t        pins_o,
    input  wire logic                 dout_i,       // Memory data out
    input  wire logic                 dout_oe_i     // Memory drives dout
);
    import drc_pkg::*;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SETUP,
        ST_ON,
        ST_OFF
    } drc_state_t;

    drc_state_t        state_r;
    drc_state_t        state_nxt;
    logic [CNT_W-1:0]  cnt_r;                  // Cycles into current cycle
    logic [CNT_W-1:0]  cnt_nxt;
    drc_op_t           op_r;                   // Operation in flight
    drc_op_t           op_nxt;
    logic              refr_r;                 // Cycle is a refresh
    logic              refr_nxt;
    drc_pins_t         pins_r;
    drc_pins_t         pins_nxt;
    logic              rdv_r;
    logic              rdv_nxt;
    logic              rdd_r;
    logic              rdd_nxt;
    logic              rdy_r;
    logic              rdy_nxt;
    logic              due;                    // Refresh pending
    logic [ROW_W-1:0]  row;                    // Next refresh row
    logic              refr_done;

    // Strobe high time for an operation
    function automatic logic [CNT_W-1:0] on_len(input drc_op_t op);
        on_len = (op == DRC_OP_RMW) ? CNT_W'(RMW_ON_CLKS) : CNT_W'(ON_CLKS);
    endfunction

    // Whole period for an operation
    function automatic logic [CNT_W-1:0] period_len(input drc_op_t op);
        period_len = (op == DRC_OP_RMW) ? CNT_W'(RMW_CLKS)
                                        : CNT_W'(CYCLE_CLKS);
    endfunction

    // Refresh pacing lives in its own small block
    drc_refresh_timer #(
        .GAP_CLKS (REFRESH_GAP)
    ) u_refresh (
        .mclk_i   (mclk_i),
        .rstn_i   (rstn_i),
        .ce_i     (ce_i),
        .done_i   (refr_done),
        .due_o    (due),
        .row_o    (row)
    );

    // Refresh counted as done when its strobe rises
    assign refr_done = (state_r == ST_SETUP) && refr_r
                       && (cnt_r >= CNT_W'(SETUP_CLKS) - CNT_ONE);

    // Cycle sequencer: idle, address setup, strobe high, strobe low
    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r + CNT_ONE;
        op_nxt    = op_r;
        refr_nxt  = refr_r;
        pins_nxt  = pins_r;
        rdv_nxt   = 1'b0;
        rdd_nxt   = rdd_r;
        rdy_nxt   = 1'b0;
        unique case (state_r)
            ST_IDLE: begin
                cnt_nxt         = CNT_ZERO;
                pins_nxt.strobe = 1'b0;
                pins_nxt.wr_n   = 1'b1;
                pins_nxt.sel_n  = 1'b1;
                // A shown ready is honoured; refresh then waits one cycle,
                // otherwise a tick landing with ready would drop a request
                if (req_valid_i && rdy_r) begin
                    state_nxt      = ST_SETUP;
                    op_nxt         = req_i.op;
                    refr_nxt       = 1'b0;
                    pins_nxt.addr  = req_i.addr;
                    pins_nxt.din   = req_i.wdata;
                    pins_nxt.sel_n = 1'b0;
                end else if (due) begin
                    state_nxt      = ST_SETUP;
                    op_nxt         = DRC_OP_READ;
                    refr_nxt       = 1'b1;
                    // Column bits zero, row in low bits
                    pins_nxt.addr  = {ADDR_ZERO[ADDR_W-1:ROW_W], row};
                    pins_nxt.sel_n = 1'b1;
                end else begin
                    rdy_nxt = 1'b1;
                end
            end
            ST_SETUP: begin
                // Address stable before the strobe rises
                if (cnt_r >= CNT_W'(SETUP_CLKS) - CNT_ONE) begin
                    state_nxt       = ST_ON;
                    cnt_nxt         = CNT_ZERO;
                    pins_nxt.strobe = 1'b1;
                end
            end
            ST_ON: begin
                // Write low well before strobe falls
                // One extra cycle: the pin only moves at the next edge
                if (!refr_r && op_r == DRC_OP_WRITE
                    && cnt_r == on_len(op_r) - CNT_W'(WE_CLKS) - CNT_ONE) begin
                    pins_nxt.wr_n = 1'b0;
                end
                // Sample read data at the access bound
                if (!refr_r && op_r != DRC_OP_WRITE
                    && cnt_r == CNT_W'(ACC_CLKS) - CNT_ONE) begin
                    rdd_nxt = dout_oe_i ? dout_i : 1'b0;
                    rdv_nxt = 1'b1;
                end
                // RMW: write back modified bit after the read
                if (!refr_r && op_r == DRC_OP_RMW
                    && cnt_r == on_len(op_r) - CNT_W'(WE_CLKS) - CNT_ONE) begin
                    pins_nxt.din  = rmw_wdata_i;
                    pins_nxt.wr_n = 1'b0;
                end
                if (cnt_r >= on_len(op_r) - CNT_ONE) begin
                    // Strobe high stays under duty limit except in RMW, high 35 of 52 cycles
                    state_nxt       = ST_OFF;
                    pins_nxt.strobe = 1'b0;
                end
            end
            ST_OFF: begin
                pins_nxt.wr_n  = 1'b1;
                pins_nxt.sel_n = 1'b1;
                // Full period counted from setup start
                if (cnt_r + CNT_W'(SETUP_CLKS) >= period_len(op_r) - CNT_ONE)
                begin
                    state_nxt = ST_IDLE;
                    cnt_nxt   = CNT_ZERO;
                    rdy_nxt   = !due;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    // Register stage, frozen while the clock enable is low
    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            state_r <= ST_IDLE;
            cnt_r   <= CNT_ZERO;
            op_r    <= DRC_OP_READ;
            refr_r  <= 1'b0;
            pins_r  <= '{strobe: 1'b0, sel_n: 1'b1, wr_n: 1'b1,
                         addr: ADDR_ZERO, din: 1'b0};
            rdv_r   <= 1'b0;
            rdd_r   <= 1'b0;
            rdy_r   <= 1'b0;
        end else if (ce_i) begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
            op_r    <= op_nxt;
            refr_r  <= refr_nxt;
            pins_r  <= pins_nxt;
            rdv_r   <= rdv_nxt;
            rdd_r   <= rdd_nxt;
            rdy_r   <= rdy_nxt;
        end
    end

    // Outputs straight from flops; busy is state_r != idle as a flop copy
    logic busy_r;
    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            busy_r <= 1'b0;
        end else if (ce_i) begin
            busy_r <= (state_nxt != ST_IDLE);
        end
    end

    assign pins_o      = pins_r;
    assign rd_valid_o  = rdv_r;
    assign rd_data_o   = rdd_r;
    assign req_ready_o = rdy_r;
    assign busy_o      = busy_r;
endmodule
`default_nettype wire

// ===== test/drc_ctrl_monitor.sv
// Pin timing checker for the dynamic RAM controller
`default_nettype none
module drc_ctrl_monitor
    import drc_pkg::*;
#(
    parameter int unsigned REFRESH_GAP = REFRESH_GAP_CLKS
) (
    input  wire logic               mclk_i,
    input  wire logic               rstn_i,
    input  wire logic               ce_i,
    input  wire logic               rd_valid_o,
    input  wire drc_pkg::drc_pins_t pins_o
);
    // Late refresh may wait behind one full user cycle
    localparam int GAP_MAX = REFRESH_GAP + RMW_CLKS + 4;
    logic [7:0]  since_r, since_nxt;    // Cycles since last strobe rise
    logic [7:0]  on_r, on_nxt;          // Length of current high run
    logic [7:0]  last_on_r, last_on_nxt; // Length of last high run
    logic [15:0] gap_r, gap_nxt;        // Cycles since last refresh
    logic [5:0]  row_r, row_nxt;        // Last refreshed row
    logic        seen_r, seen_nxt;      // A refresh has been seen
    logic        prev_r;                // Strobe one edge ago
    logic        rise;
    logic        fall;
    assign rise = pins_o.strobe && !prev_r;
    assign fall = !pins_o.strobe && prev_r;
    // Counters only move on enabled cycles, as the design freezes otherwise
    always_comb begin
        since_nxt   = since_r;
        on_nxt      = on_r;
        last_on_nxt = last_on_r;
        gap_nxt     = gap_r;
        row_nxt     = row_r;
        seen_nxt    = seen_r;
        if (ce_i) begin
            if (rise) since_nxt = 8'h01;
            else if (since_r != 8'hff) since_nxt = since_r + 8'h01;
            if (!pins_o.strobe) on_nxt = 8'h00;
            else if (on_r != 8'hff) on_nxt = on_r + 8'h01;
            if (fall) last_on_nxt = on_r;
            if (rise && pins_o.sel_n) begin
                gap_nxt  = 16'h0000;
                row_nxt  = pins_o.addr[5:0];
                seen_nxt = 1'b1;
            end else if (gap_r != 16'hffff) begin
                gap_nxt = gap_r + 16'h0001;
            end
        end
    end
    // Registers only; saturated start keeps the first cycle legal
    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            since_r   <= 8'hff;
            on_r      <= 8'h00;
            last_on_r <= 8'h00;
            gap_r     <= 16'h0000;
            row_r     <= 6'h00;
            seen_r    <= 1'b0;
            prev_r    <= 1'b0;
        end else begin
            since_r   <= since_nxt;
            on_r      <= on_nxt;
            last_on_r <= last_on_nxt;
            gap_r     <= gap_nxt;
            row_r     <= row_nxt;
            seen_r    <= seen_nxt;
            prev_r    <= pins_o.strobe;
        end
    end
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rstn_i);
    AST_CYCLE_MIN: assert property (rise |-> since_r >= CYCLE_CLKS)
        else $error("cycle started too soon");
    AST_RMW_MIN: assert property (
        rise && last_on_r >= RMW_ON_CLKS |-> since_r >= RMW_CLKS)
        else $error("cycle after rmw started too soon");
    AST_ON_WIDTH: assert property (
        fall |-> on_r == ON_CLKS || on_r == RMW_ON_CLKS)
        else $error("strobe high time wrong");
    AST_ADDR_HOLD: assert property (
        pins_o.strobe |-> $stable({pins_o.addr, pins_o.sel_n}))
        else $error("address moved while strobe high");
    AST_WR_SEL: assert property (!pins_o.wr_n |-> !pins_o.sel_n)
        else $error("write strobe low without select");
    AST_WR_FALL: assert property (
        $fell(pins_o.wr_n) |-> pins_o.strobe && $past(pins_o.strobe))
        else $error("write strobe fell outside a cycle");
    AST_RD_IN_CYCLE: assert property (
        rd_valid_o |-> pins_o.strobe && !pins_o.sel_n)
        else $error("read data taken outside a selected cycle");
    AST_REFRESH_ROW: assert property (rise && pins_o.sel_n |->
        pins_o.addr[11:6] == 6'h00 &&
        pins_o.addr[5:0] == (seen_r ? row_r + 6'h01 : 6'h00))
        else $error("refresh row out of order");
    AST_REFRESH_GAP: assert property (gap_r <= GAP_MAX)
        else $error("refresh overdue");
endmodule
bind drc_ctrl drc_ctrl_monitor #(.REFRESH_GAP(REFRESH_GAP)) i_mon (
    .mclk_i(mclk_i), .rstn_i(rstn_i), .ce_i(ce_i),
    .rd_valid_o(rd_valid_o), .pins_o(pins_o));
`default_nettype wire

// ===== test/drc_mem_model.sv
// Behavioural model of the 4K x 1 dynamic memory on the controller pins
`default_nettype none
module drc_mem_model
    import drc_pkg::*;
(
    input  wire logic               mclk_i,
    input  wire logic               slow_i,    // Answer late in the read
    input  wire drc_pkg::drc_pins_t pins_i,
    output logic                    dout_o,
    output logic                    dout_oe_o
);
    logic              mem [0:4095];
    logic [ADDR_W-1:0] lat_r;              // Address taken at cycle start
    logic [7:0]        age_r  = 8'hff;     // Edges since strobe rose
    logic              prev_r = 1'b0;      // Strobe one edge ago
    logic              last_r = 1'b0;      // Last bit driven
    initial foreach (mem[i]) mem[i] = 1'b0;
    // Latch on the rising strobe, store while write strobe is low
    always @(posedge mclk_i) begin
        prev_r <= pins_i.strobe;
        if (pins_i.strobe && !prev_r) begin
            lat_r <= pins_i.addr;
            age_r <= 8'h00;
        end else if (age_r != 8'hff) begin
            age_r <= age_r + 8'h01;
        end
        if (pins_i.strobe && prev_r && !pins_i.wr_n && !pins_i.sel_n) begin
            mem[lat_r] <= pins_i.din;
        end
        if (dout_oe_o) begin
            last_r <= dout_o;
        end
    end
    // Drive only inside a selected cycle; early data is deliberately wrong
    always_comb begin
        dout_oe_o = pins_i.strobe && prev_r && !pins_i.sel_n;
        if (!dout_oe_o)
            dout_o = ~last_r;                // No stale value after release
        else if (age_r >= (slow_i ? 8'h11 : 8'h01))
            dout_o = mem[lat_r];
        else
            dout_o = ~mem[lat_r];
    end
endmodule
`default_nettype wire

// ===== test/testbench.sv
// Self-checking bench for the dynamic RAM controller and memory model
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import drc_pkg::*;
    localparam int unsigned GAP = 200;   // Short refresh spacing
    logic              mclk_i      = 1'b0;
    logic              rstn_i      = 1'b0;
    logic              ce_i        = 1'b1;
    logic              req_valid_i = 1'b0;
    drc_req_t          req_i       = '0;
    logic              rmw_wdata_i = 1'b0;
    logic              slow_i      = 1'b0;
    logic              req_ready_o, rd_valid_o, rd_data_o, busy_o;
    logic              dout_i, dout_oe_i, prev_strobe;
    drc_pins_t         pins_o;
    logic              exp_mem [0:4095];  // Expected contents
    logic [ADDR_W-1:0] corner [5] = '{12'h000, 12'hfff, 12'h03f, 12'h040,
                                      12'hfc0};
    int                bad_count = 0;
    int                checks    = 0;
    int                cycles    = 0;
    int                refreshes = 0;
    drc_ctrl #(.REFRESH_GAP(GAP)) i_drc_ctrl (.mclk_i(mclk_i),
        .rstn_i(rstn_i), .ce_i(ce_i), .req_valid_i(req_valid_i),
        .req_i(req_i), .req_ready_o(req_ready_o), .rmw_wdata_i(rmw_wdata_i),
        .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o), .busy_o(busy_o),
        .pins_o(pins_o), .dout_i(dout_i), .dout_oe_i(dout_oe_i));
    drc_mem_model i_drc_mem_model (.mclk_i(mclk_i), .slow_i(slow_i),
        .pins_i(pins_o), .dout_o(dout_i), .dout_oe_o(dout_oe_i));
    always #5 mclk_i = ~mclk_i;
    // Cycle ceiling and refresh count
    always @(posedge mclk_i) begin
        cycles++;
        prev_strobe <= pins_o.strobe;
        if (rstn_i && pins_o.strobe && !prev_strobe && pins_o.sel_n)
            refreshes++;
        if (cycles == 60000) begin
            bad_count++;
            tally_and_finish();
        end
    end
    task automatic check(input string what, input logic seen,
                         input logic exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %s expected %b seen %b", what, exp, seen);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // One user cycle; RMW gets the wrong bit on req_i to show it is unused
    task automatic do_op(input drc_op_t op, input logic [ADDR_W-1:0] a,
                         input logic d);
        int   n;
        logic old;
        n   = 0;
        old = exp_mem[a];
        @(posedge mclk_i);
        req_valid_i <= 1'b1;
        req_i       <= '{op: op, addr: a, wdata: (op == DRC_OP_RMW) ^ d};
        rmw_wdata_i <= d;
        slow_i      <= 1'($urandom_range(1));
        do begin @(negedge mclk_i); n++; end
        while (req_ready_o !== 1'b1 && n < 400);
        check("req_ready_o", req_ready_o, 1'b1);
        @(posedge mclk_i);
        req_valid_i <= 1'b0;
        if (op != DRC_OP_WRITE) begin
            n = 0;
            do begin @(negedge mclk_i); n++; end
            while (rd_valid_o !== 1'b1 && n < 100);
            check("rd_valid_o", rd_valid_o, 1'b1);
            check("rd_data_o", rd_data_o, old);
            check("busy_o", busy_o, 1'b1);
        end
        if (op != DRC_OP_READ) exp_mem[a] = d;
    endtask
    initial begin
        logic [ADDR_W-1:0] a;
        void'($urandom(37804));
        foreach (exp_mem[i]) exp_mem[i] = 1'b0;
        repeat (4) @(posedge mclk_i);
        rstn_i <= 1'b1;
        @(negedge mclk_i);
        check("strobe", pins_o.strobe, 1'b0);
        check("sel_n", pins_o.sel_n, 1'b1);
        check("busy_o", busy_o, 1'b0);
        // Corner addresses: write, read twice back to back, then RMW
        foreach (corner[i]) do_op(DRC_OP_WRITE, corner[i], 1'b1);
        foreach (corner[i]) begin
            do_op(DRC_OP_READ, corner[i], 1'b0);
            do_op(DRC_OP_READ, corner[i], 1'b0);
        end
        foreach (corner[i]) do_op(DRC_OP_RMW, corner[i], 1'(i));
        // Random traffic over a small address pool, with enable drops
        repeat (80) begin
            a = 12'($urandom_range(4095)) & 12'h0c3;
            do_op(drc_op_t'($urandom_range(2)), a, 1'($urandom_range(1)));
            if ($urandom_range(3) == 0) begin
                ce_i <= 1'b0;
                @(posedge mclk_i);
                ce_i <= 1'b1;
            end
        end
        // Long idle lets refresh sweep every row, data must survive
        repeat (64 * GAP + 400) @(posedge mclk_i);
        check("refresh sweep", refreshes >= 64, 1'b1);
        foreach (corner[i]) do_op(DRC_OP_READ, corner[i], 1'b0);
        tally_and_finish();
    end
endmodule
`default_nettype wire
